// ### design/hec_core.sv
// Control core of the code hopping encoder
`timescale 1ns/100ps
`default_nettype none
`include "hec_params.svh"

// Functional notes
// - Wake on any switch, debounce 10 ms
// - Encrypt counter, discrimination and buttons together
// - New button mid-word restarts processing
// - Partial release ignored; full release finishes, sleeps
// - Store holds twelve 16-bit words
// - Key in words 0-3, word 0 lowest
// - Word 4 counter written back each transmission
// - Counter incremented before encryption
// - Serial in words 6-7, 28 bits sent
// - Serial bit 31 enables shutoff timer
// - Shutoff after 25 s stops transmitting
// - Word 11 bits 0-9 discrimination value
// - Option word flag and select bit layout
// - Rate bits pick element and word blanking
// - Threshold select bit chooses supply assumption
// - Wraps clear first, then second flag
// - Cleared wrap flags set again only by programming
// - Programming: third switch clocks, pulse pin data
module hec_core
	import hec_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = `HEC_DEBOUNCE_MS * (`HEC_CLOCK_HZ / 1000),
	parameter int SHUTOFF_CYCLES = `HEC_SHUTOFF_S * `HEC_CLOCK_HZ
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Switch inputs
	input wire logic switch_in_a,
	input wire logic switch_in_b,
	input wire logic switch_in_c_prog_clock,
	input wire logic prog_mode,
	// Pulse pin, data line while programming
	input wire logic pulse_in,
	output logic pulse_out,
	output logic pulse_oe_n,
	// Cipher engine
	output logic cipher_start,
	output logic [63:0] cipher_key,
	output logic [31:0] cipher_plain,
	input wire logic cipher_done,
	input wire logic [31:0] cipher_result,
	// Code word framing stage
	output logic word_start,
	output logic word_send,
	output logic [31:0] word_hop,
	output logic [27:0] word_serial,
	output logic [3:0] word_buttons,
	output logic element_tick,
	input wire logic word_done,
	// Status
	output logic awake,
	output logic timeout_active,
	output logic battery_threshold_select,
	output logic rate_select_lo,
	output logic rate_select_hi
);
	localparam int ELEM_SLOW = `HEC_ELEM_SLOW_US * (`HEC_CLOCK_HZ / 1000000);
	localparam int ELEM_MID = `HEC_ELEM_MID_US * (`HEC_CLOCK_HZ / 1000000);
	localparam int ELEM_FAST = `HEC_ELEM_FAST_US * (`HEC_CLOCK_HZ / 1000000);
	localparam int WAIT_W = $clog2(DEBOUNCE_CYCLES + 1);
	localparam int ACT_W = $clog2(SHUTOFF_CYCLES + 1);

	hec_state_type state_q, state_d;
	logic [WAIT_W-1:0] wait_q, wait_d;
	logic [ACT_W-1:0] active_q, active_d;
	logic [3:0] btn_q, btn_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] cfg_q, cfg_d;
	logic [31:0] hop_q, hop_d;
	logic [1:0] word_idx_q, word_idx_d;
	logic [11:0] elem_q, elem_d;
	logic tick_q, tick_d;
	logic cstart_q, cstart_d;
	logic wstart_q, wstart_d;
	logic [15:0] shift_q, shift_d;
	logic [3:0] bit_q, bit_d;
	logic [4:0] paddr_q, paddr_d;
	logic pclk_q, pclk_d;
	logic pout_q, pout_d;
	logic poe_n_q, poe_n_d;

	logic [2:0] sw_now;
	logic any_sw;
	logic pclk_rise;
	logic st_we;
	logic [3:0] st_waddr;
	logic [15:0] st_wdata;
	logic [3:0] rd_addr;
	logic [15:0] rd_data;
	logic [63:0] key_value;
	logic [15:0] counter_value;
	logic [31:0] serial_value;
	logic [15:0] option_value;
	logic [1:0] rate;
	logic [11:0] elem_reload;
	logic shutoff_en;
	logic running;

	hec_store u_store (
		.clock(clock),
		.wr_en(st_we),
		.wr_addr(st_waddr),
		.wr_data(st_wdata),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.key_value(key_value),
		.counter_value(counter_value),
		.serial_value(serial_value),
		.option_value(option_value)
	);

	assign sw_now = {switch_in_c_prog_clock, switch_in_b, switch_in_a};
	assign any_sw = |sw_now;
	assign pclk_rise = switch_in_c_prog_clock && !pclk_q;
	assign rate = {option_value[`HEC_RATE_HI], option_value[`HEC_RATE_LO]};
	assign shutoff_en = serial_value[16 + `HEC_SHUTOFF_EN];
	assign running = (state_q != ST_SLEEP) && (state_q != ST_PROG) &&
		(state_q != ST_TIMEOUT);
	// Readback walks the same twelve words after loading
	assign rd_addr = 4'(paddr_q - 5'(`HEC_WORDS));

	// Basic pulse element per rate code
	always_comb begin
		case (rate)
			2'b00: elem_reload = 12'(ELEM_SLOW - 1);
			2'b01: elem_reload = 12'(ELEM_MID - 1);
			default: elem_reload = 12'(ELEM_FAST - 1);
		endcase
	end

	// Store write mux: counter, option word, or programmer
	always_comb begin
		st_we = 1'b0;
		st_waddr = `HEC_ADDR_COUNTER;
		st_wdata = cnt_q;
		case (state_q)
			ST_WR_COUNTER: begin
				st_we = 1'b1;
			end
			ST_WR_OPTION: begin
				st_we = 1'b1;
				st_waddr = `HEC_ADDR_OPTION;
				st_wdata = cfg_q;
			end
			ST_PROG: begin
				st_we = pclk_rise && (paddr_q < 5'(`HEC_WORDS)) &&
					(bit_q == 4'hF);
				st_waddr = paddr_q[3:0];
				st_wdata = {shift_q[14:0], pulse_in};
			end
			default: begin
				st_we = 1'b0;
			end
		endcase
	end

	always_comb begin
		state_d = state_q;
		wait_d = wait_q;
		active_d = active_q;
		btn_d = btn_q;
		cnt_d = cnt_q;
		cfg_d = cfg_q;
		hop_d = hop_q;
		word_idx_d = word_idx_q;
		elem_d = elem_q;
		tick_d = 1'b0;
		cstart_d = 1'b0;
		wstart_d = 1'b0;
		shift_d = shift_q;
		bit_d = bit_q;
		paddr_d = paddr_q;
		pclk_d = switch_in_c_prog_clock;
		pout_d = pout_q;
		poe_n_d = 1'b1;
		case (state_q)
			ST_SLEEP: begin
				if (prog_mode) begin
					state_d = ST_PROG;
					bit_d = 4'h0;
					paddr_d = 5'h00;
					pclk_d = 1'b1;
				end else if (any_sw) begin
					state_d = ST_DEBOUNCE;
					wait_d = WAIT_W'(DEBOUNCE_CYCLES - 1);
					active_d = '0;
				end
			end
			ST_DEBOUNCE: begin
				if (wait_q != '0) begin
					wait_d = wait_q - 1'b1;
				end else if (any_sw) begin
					btn_d = {1'b0, sw_now};
					cnt_d = counter_value + 16'h0001;
					cfg_d = option_value;
					// Flags only ever go to zero here
					if (counter_value == 16'hFFFF) begin
						if (option_value[`HEC_WRAP_FIRST]) begin
							cfg_d[`HEC_WRAP_FIRST] = 1'b0;
						end else begin
							cfg_d[`HEC_WRAP_SECOND] = 1'b0;
						end
					end
					state_d = ST_WR_COUNTER;
				end else begin
					state_d = ST_SLEEP;
				end
			end
			ST_WR_COUNTER: begin
				state_d = ST_WR_OPTION;
			end
			ST_WR_OPTION: begin
				state_d = ST_ENCRYPT;
			end
			ST_ENCRYPT: begin
				cstart_d = 1'b1;
				state_d = ST_WAIT_CIPHER;
			end
			ST_WAIT_CIPHER: begin
				if (cipher_done) begin
					hop_d = cipher_result;
					word_idx_d = 2'b00;
					wstart_d = 1'b1;
					elem_d = elem_reload;
					state_d = ST_SEND;
				end
			end
			ST_SEND: begin
				if (elem_q == 12'h000) begin
					elem_d = elem_reload;
					tick_d = 1'b1;
				end else begin
					elem_d = elem_q - 12'h001;
				end
				if ((sw_now & ~btn_q[2:0]) != 3'b000) begin
					state_d = ST_DEBOUNCE;
					wait_d = WAIT_W'(DEBOUNCE_CYCLES - 1);
				end else if (word_done) begin
					if (any_sw) begin
						word_idx_d = word_idx_q + 2'b01;
						wstart_d = 1'b1;
					end else begin
						state_d = ST_SLEEP;
					end
				end
			end
			ST_TIMEOUT: begin
				if (!any_sw) begin
					state_d = ST_SLEEP;
				end
			end
			ST_PROG: begin
				// Programmer writes all twelve words, 0 to 11; loaded as sent
				if (!prog_mode) begin
					state_d = ST_SLEEP;
				end else if (pclk_rise) begin
					if (paddr_q < 5'(`HEC_WORDS)) begin
						shift_d = {shift_q[14:0], pulse_in};
						bit_d = bit_q + 4'h1;
						if (bit_q == 4'hF) begin
							paddr_d = paddr_q + 5'h01;
						end
					end else if (paddr_q < 5'(2 * `HEC_WORDS)) begin
						pout_d = rd_data[4'hF - bit_q];
						bit_d = bit_q + 4'h1;
						if (bit_q == 4'hF) begin
							paddr_d = paddr_q + 5'h01;
						end
					end
				end
				// Drive the line only during readback
				poe_n_d = !((paddr_q >= 5'(`HEC_WORDS)) &&
					(paddr_q < 5'(2 * `HEC_WORDS)) && prog_mode);
			end
			default: begin
				state_d = ST_SLEEP;
			end
		endcase
		// Stuck-button guard overrides every awake state except ST_PROG and ST_TIMEOUT
		if (running && shutoff_en) begin
			if (active_q == ACT_W'(SHUTOFF_CYCLES - 1)) begin
				state_d = ST_TIMEOUT;
				wstart_d = 1'b0;
				cstart_d = 1'b0;
			end else begin
				active_d = active_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_q <= ST_SLEEP;
			wait_q <= '0;
			active_q <= '0;
			btn_q <= 4'h0;
			cnt_q <= 16'h0000;
			cfg_q <= 16'h0000;
			hop_q <= 32'h00000000;
			word_idx_q <= 2'b00;
			elem_q <= 12'h000;
			tick_q <= 1'b0;
			cstart_q <= 1'b0;
			wstart_q <= 1'b0;
			shift_q <= 16'h0000;
			bit_q <= 4'h0;
			paddr_q <= 5'h00;
			pclk_q <= 1'b1;
			pout_q <= 1'b0;
			poe_n_q <= 1'b1;
		end else begin
			state_q <= state_d;
			wait_q <= wait_d;
			active_q <= active_d;
			btn_q <= btn_d;
			cnt_q <= cnt_d;
			cfg_q <= cfg_d;
			hop_q <= hop_d;
			word_idx_q <= word_idx_d;
			elem_q <= elem_d;
			tick_q <= tick_d;
			cstart_q <= cstart_d;
			wstart_q <= wstart_d;
			shift_q <= shift_d;
			bit_q <= bit_d;
			paddr_q <= paddr_d;
			pclk_q <= pclk_d;
			pout_q <= pout_d;
			poe_n_q <= poe_n_d;
		end
	end

	// Plaintext: buttons, option bits 0-11, fresh counter
	assign cipher_plain = {btn_q, cfg_q[`HEC_WRAP_SECOND:0], cnt_q};
	assign cipher_key = key_value;
	assign cipher_start = cstart_q;
	assign word_start = wstart_q;
	assign word_hop = hop_q;
	assign word_serial = serial_value[`HEC_SERIAL_TX_W-1:0];
	assign word_buttons = btn_q;
	assign element_tick = tick_q;
	// Blanking keeps average power down on the faster rates
	assign word_send = (rate == 2'b00) ? 1'b1 :
		(rate == 2'b11) ? (word_idx_q == 2'b00) :
		!word_idx_q[0];
	assign pulse_out = pout_q;
	assign pulse_oe_n = poe_n_q;
	assign awake = (state_q != ST_SLEEP);
	assign timeout_active = (state_q == ST_TIMEOUT);
	assign battery_threshold_select = option_value[`HEC_BATT_SEL];
	assign rate_select_lo = option_value[`HEC_RATE_LO];
	assign rate_select_hi = option_value[`HEC_RATE_HI];
endmodule
`default_nettype wire

// ### design/hec_params.svh
// Offsets, field positions and timing figures of the encoder control store
`ifndef HEC_PARAMS_SVH
`define HEC_PARAMS_SVH

`define HEC_WORDS 12
`define HEC_WORD_W 16
`define HEC_ADDR_W 4

`define HEC_ADDR_KEY_0 4'h0
`define HEC_ADDR_KEY_1 4'h1
`define HEC_ADDR_KEY_2 4'h2
`define HEC_ADDR_KEY_3 4'h3
`define HEC_ADDR_COUNTER 4'h4
`define HEC_ADDR_RSV_A 4'h5
`define HEC_ADDR_SERIAL_LO 4'h6
`define HEC_ADDR_SERIAL_HI 4'h7
`define HEC_ADDR_UNUSED_A 4'h8
`define HEC_ADDR_UNUSED_B 4'h9
`define HEC_ADDR_RSV_B 4'hA
`define HEC_ADDR_OPTION 4'hB

`define HEC_DISC_MSB 9
`define HEC_WRAP_FIRST 10
`define HEC_WRAP_SECOND 11
`define HEC_BATT_SEL 12
`define HEC_RATE_LO 13
`define HEC_RATE_HI 14
`define HEC_SHUTOFF_EN 15
`define HEC_SERIAL_TX_W 28

`define HEC_CLOCK_HZ 10000000
`define HEC_DEBOUNCE_MS 10
`define HEC_SHUTOFF_S 25
`define HEC_ELEM_SLOW_US 400
`define HEC_ELEM_MID_US 200
`define HEC_ELEM_FAST_US 100

`endif

// ### design/hec_pkg.sv
// Types shared by the encoder control core
package hec_pkg;
	typedef enum logic [3:0] {
		ST_SLEEP,
		ST_DEBOUNCE,
		ST_WR_COUNTER,
		ST_WR_OPTION,
		ST_ENCRYPT,
		ST_WAIT_CIPHER,
		ST_SEND,
		ST_TIMEOUT,
		ST_PROG
	} hec_state_type;
endpackage

// ### design/hec_store.sv
// Twelve-word nonvolatile parameter array
`timescale 1ns/100ps
`default_nettype none
`include "hec_params.svh"

module hec_store #(
	parameter int WORDS = `HEC_WORDS
) (
	// Clock
	input wire logic clock,
	// Write port
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [15:0] wr_data,
	// Read port
	input wire logic [3:0] rd_addr,
	output logic [15:0] rd_data,
	// Fixed views
	output logic [63:0] key_value,
	output logic [15:0] counter_value,
	output logic [31:0] serial_value,
	output logic [15:0] option_value
);
	// No reset: contents survive power-down
	logic [15:0] mem_q [WORDS];

	always_ff @(posedge clock) begin
		if (wr_en && (32'(wr_addr) < WORDS)) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	assign rd_data = (32'(rd_addr) < WORDS) ? mem_q[rd_addr] : 16'h0000;
	assign key_value = {mem_q[`HEC_ADDR_KEY_3], mem_q[`HEC_ADDR_KEY_2],
		mem_q[`HEC_ADDR_KEY_1], mem_q[`HEC_ADDR_KEY_0]};
	assign counter_value = mem_q[`HEC_ADDR_COUNTER];
	assign serial_value = {mem_q[`HEC_ADDR_SERIAL_HI],
		mem_q[`HEC_ADDR_SERIAL_LO]};
	assign option_value = mem_q[`HEC_ADDR_OPTION];
endmodule
`default_nettype wire

// ### sim/hec_core_checker.sv
// Port-level assertions for the encoder control core
`timescale 1ns/100ps
`default_nettype none

module hec_core_checker #(
	parameter int DEBOUNCE_CYCLES = 20,
	parameter int SHUTOFF_CYCLES = 400
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Switches
	input wire logic switch_in_a,
	input wire logic switch_in_b,
	input wire logic switch_in_c_prog_clock,
	// Handshakes
	input wire logic cipher_start,
	input wire logic cipher_done,
	input wire logic [31:0] cipher_result,
	input wire logic word_start,
	input wire logic word_send,
	input wire logic [31:0] word_hop,
	input wire logic word_done,
	// Status
	input wire logic awake,
	input wire logic timeout_active,
	input wire logic rate_select_lo,
	input wire logic rate_select_hi
);
	logic sw;
	assign sw = switch_in_a | switch_in_b | switch_in_c_prog_clock;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	sequence s_wake;
		!awake ##1 awake;
	endsequence
	sequence s_back;
		cipher_done && awake && !timeout_active;
	endsequence
	a_debounce_quiet: assert property (
		s_wake |-> !cipher_start [*8]) else $error("early cipher start");
	a_hop_from_cipher: assert property (
		s_back |=> word_start && word_hop == $past(cipher_result))
		else $error("hop not taken from cipher");
	a_start_single: assert property (
		cipher_start |=> !cipher_start [*3]) else $error("cipher start repeated");
	a_word_repeat: assert property (
		word_done && sw && !timeout_active |=> word_start)
		else $error("held switch gave no new word");
	a_word_finish: assert property (
		word_done && !sw && !timeout_active |=> !awake)
		else $error("no sleep after last word");
	a_timeout_hold: assert property (
		timeout_active && sw |=> timeout_active) else $error("timeout left early");
	a_timeout_exit: assert property (
		timeout_active && !sw |=> !awake && !timeout_active)
		else $error("timeout not left on release");
	a_timeout_quiet: assert property (
		timeout_active |-> !word_start && !cipher_start)
		else $error("activity in timeout");
	a_rate_all_sent: assert property (
		word_start && !rate_select_lo && !rate_select_hi |-> word_send)
		else $error("word blanked at full rate");
	a_first_sent: assert property (
		s_back |=> word_send) else $error("first word blanked");
endmodule

bind hec_core hec_core_checker #(
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
	.SHUTOFF_CYCLES(SHUTOFF_CYCLES)
) u_checker (.clock, .resetn, .switch_in_a, .switch_in_b,
	.switch_in_c_prog_clock, .cipher_start, .cipher_done, .cipher_result,
	.word_start, .word_send, .word_hop, .word_done, .awake, .timeout_active,
	.rate_select_lo, .rate_select_hi);

`default_nettype wire

// ### sim/hec_far_side.sv
// Cipher engine and code word framer facing the core
`timescale 1ns/100ps
`default_nettype none

module hec_far_side #(
	parameter int CIPHER_LAT = 4,
	parameter int WORD_LEN = 50
) (
	// Clock
	input wire logic clock,
	// Cipher engine
	input wire logic cipher_start,
	input wire logic [63:0] cipher_key,
	input wire logic [31:0] cipher_plain,
	output logic cipher_done,
	output logic [31:0] cipher_result,
	// Framer
	input wire logic word_start,
	output logic word_done
);
	int c_cnt = 0;
	int w_cnt = 0;
	// Stand-in cipher; result toggles outside its done cycle
	initial begin
		cipher_done = 1'b0;
		word_done = 1'b0;
		cipher_result = 32'h0000_0000;
		forever @(negedge clock) begin
			cipher_done <= (c_cnt == 1);
			cipher_result <= (c_cnt == 1) ? cipher_plain ^ cipher_key[63:32] :
				~cipher_result;
			word_done <= (w_cnt == 1);
			c_cnt <= cipher_start ? CIPHER_LAT : (c_cnt > 0 ? c_cnt - 1 : 0);
			// A new word restarts the frame, so an aborted word completes only if no new start comes
			w_cnt <= word_start ? WORD_LEN : (w_cnt > 0 ? w_cnt - 1 : 0);
		end
	end
endmodule

`default_nettype wire

// ### sim/hec_core_tb.sv
// Self-checking bench for the encoder control core
`timescale 1ns/100ps
`default_nettype none

module hec_core_tb;
	logic clock, resetn, switch_in_a, switch_in_b, switch_in_c_prog_clock;
	logic prog_mode, prog_data, pulse_in, pulse_out, pulse_oe_n, awake;
	logic cipher_start, cipher_done, word_start, word_send, word_done;
	logic element_tick, timeout_active, battery_threshold_select;
	logic rate_select_lo, rate_select_hi;
	logic [63:0] cipher_key;
	logic [31:0] cipher_plain, cipher_result, word_hop;
	logic [27:0] word_serial;
	logic [3:0] word_buttons;
	logic [15:0] img [12];
	int n_mismatch = 0;
	int cmp_count = 0;
	assign pulse_in = pulse_oe_n ? prog_data : pulse_out;

	hec_core #(.DEBOUNCE_CYCLES(20), .SHUTOFF_CYCLES(400)) DUT (.clock,
		.resetn, .switch_in_a, .switch_in_b, .switch_in_c_prog_clock,
		.prog_mode, .pulse_in, .pulse_out, .pulse_oe_n, .cipher_start,
		.cipher_key, .cipher_plain, .cipher_done, .cipher_result, .word_start,
		.word_send, .word_hop, .word_serial, .word_buttons, .element_tick,
		.word_done, .awake, .timeout_active, .battery_threshold_select,
		.rate_select_lo, .rate_select_hi);
	hec_far_side u_far (.clock, .cipher_start, .cipher_key, .cipher_plain,
		.cipher_done, .cipher_result, .word_start, .word_done);

	task automatic chk(input string what, input logic [63:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Bounded wait: 0 cipher start, 1 word start, 2 word done, 3 timeout
	task automatic await(input int k, output int n);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (n < 600 && (k == 0 ? cipher_start : k == 1 ? word_start :
			k == 2 ? word_done : timeout_active) !== 1'b1);
		chk("await", n < 600, 1'b1);
	endtask

	task automatic sleep_chk();
		int n;
		{switch_in_c_prog_clock, switch_in_b, switch_in_a} = 3'b000;
		await(2, n);
		@(negedge clock);
		chk("sleep", awake, 1'b0);
	endtask

	task automatic t_reset();
		repeat (6) @(negedge clock);
		chk("reset", {awake, pulse_oe_n, cipher_start, word_start}, 4'b0100);
		resetn = 1'b1;
		@(negedge clock);
	endtask

	// Full load then readback; the counter always restarts at its top value
	task automatic prog_cycle(input logic [15:0] opt);
		logic b;
		logic [2:0] o;
		img[11] = opt;
		img[4] = 16'hFFFF;
		prog_mode = 1'b1;
		repeat (2) @(negedge clock);
		for (int i = 0; i < 384; i++) begin
			b = img[(i % 192) / 16][15 - i % 16];
			prog_data = b;
			switch_in_c_prog_clock = 1'b1;
			@(negedge clock);
			// Look one cycle after the rise; the pin is freed after the last bit
			if (i >= 192)
				chk("readback", {pulse_oe_n, pulse_out}, {1'b0, b});
			@(negedge clock);
			switch_in_c_prog_clock = 1'b0;
			@(negedge clock);
		end
		{prog_mode, prog_data} = 2'b00;
		repeat (2) @(negedge clock);
		o = {rate_select_hi, rate_select_lo, battery_threshold_select};
		chk("options", o, opt[14:12]);
	endtask

	task automatic t_bounce();
		int hits;
		hits = 0;
		switch_in_a = 1'b1;
		repeat (5) @(negedge clock);
		switch_in_a = 1'b0;
		repeat (40) begin
			@(negedge clock);
			hits += cipher_start;
		end
		chk("bounce", {hits[3:0], awake}, 5'b00000);
	endtask

	task automatic press_once(input logic [2:0] sw, input logic [15:0] cnt,
		input logic [11:0] opt);
		logic [31:0] plain;
		int n;
		plain = {1'b0, sw, opt, cnt};
		{switch_in_c_prog_clock, switch_in_b, switch_in_a} = sw;
		await(0, n);
		chk("debounce", n > 20, 1'b1);
		chk("key", cipher_key, {img[3], img[2], img[1], img[0]});
		chk("plain", cipher_plain, plain);
		await(1, n);
		chk("hop", word_hop, plain ^ {img[3], img[2]});
		chk("serial", word_serial, {img[7][11:0], img[6]});
		chk("buttons", word_buttons, {1'b0, sw});
		sleep_chk();
	endtask

	task automatic t_restart();
		int n;
		switch_in_a = 1'b1;
		await(1, n);
		switch_in_b = 1'b1;
		await(0, n);
		chk("restart", {n > 20, cipher_plain}, 33'h1_3955_0003);
		sleep_chk();
	endtask

	task automatic t_timeout();
		int n;
		switch_in_a = 1'b1;
		await(3, n);
		repeat (3) @(negedge clock);
		chk("held off", timeout_active, 1'b1);
		switch_in_a = 1'b0;
		repeat (2) @(negedge clock);
		chk("off exit", {timeout_active, awake}, 2'b00);
		// Let a frame left pending by the framer run out
		repeat (60) @(negedge clock);
	endtask

	task automatic t_held();
		logic [31:0] hop;
		int n;
		{switch_in_b, switch_in_a} = 2'b11;
		await(0, n);
		chk("wrap two", cipher_plain, 32'h3155_0000);
		await(1, n);
		hop = word_hop;
		chk("send first", word_send, 1'b1);
		switch_in_b = 1'b0;
		for (int k = 1; k < 5; k++) begin
			await(1, n);
			chk("send", {word_send, word_hop}, {k == 4, hop});
		end
		sleep_chk();
	endtask

	// Element pace at rate 11, held well past the shutoff span
	task automatic t_tick();
		int n;
		switch_in_a = 1'b1;
		await(1, n);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (n < 1200 && element_tick !== 1'b1);
		chk("element", n, 1000); // 100 us at 10 MHz
		chk("no shutoff", {timeout_active, awake}, 2'b01);
		sleep_chk();
	endtask

	// Half-rate codes: every second word on air
	task automatic t_half(input logic [15:0] opt);
		int n;
		prog_cycle(opt);
		switch_in_a = 1'b1;
		await(0, n);
		chk("flags kept", cipher_plain[27:16], 12'h155);
		for (int k = 0; k < 3; k++) begin
			await(1, n);
			chk("half send", word_send, k != 1);
		end
		sleep_chk();
	endtask

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial begin
		#2000000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		resetn = 1'b0;
		{prog_mode, prog_data} = 2'b00;
		{switch_in_c_prog_clock, switch_in_b, switch_in_a} = 3'b000;
		img = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'hFFFF, 16'h0000,
			16'h5678, 16'h8ABC, 16'h0000, 16'h0000, 16'h0000, 16'h0D55};
		t_reset();
		prog_cycle(16'h0D55);
		t_bounce();
		press_once(3'b001, 16'h0000, 12'h955);
		press_once(3'b100, 16'h0001, 12'h955);
		t_restart();
		t_timeout();
		// Shutoff timer off from here on
		img[7] = 16'h0ABC;
		prog_cycle(16'h7955);
		t_held();
		t_tick();
		t_half(16'h2155);
		t_half(16'h4155);
		report_and_stop();
	end
endmodule

`default_nettype wire
